// ---- design/esp_serial_port.sv ----
// Two-wire register slave with reset defaults and mode 3 frame detection.
module esp_serial_port #(
	parameter bit COPY_PROTECT = 1'b1
) (
	input wire logic clk, // System clock, 20 MHz.
	input wire logic reset_n, // Synchronous reset, active low.
	input wire logic serial_clock_line, // Bus clock pin.
	input wire logic serial_data_line_i, // Bus data pin level.
	output logic serial_data_line_o, // Bus data drive value, always low.
	output logic serial_data_line_oe, // High while pulling data low.
	input wire logic addr_select_pin, // Sets address bit one.
	input wire logic hsync_pin, // Line sync input.
	input wire logic field_pin, // Odd/even field input.
	output logic frame_start, // One-cycle pulse at a new frame.
	output logic field_parity, // Synchronised field level.
	output esp_pkg::esp_video_ctrl_s video_ctrl // Decoded mode controls.
);
	localparam int REG_COUNT = COPY_PROTECT ? esp_pkg::REG_COUNT_CP :
		esp_pkg::REG_COUNT_PLAIN;
	localparam logic [5:0] LAST_REG = 6'(REG_COUNT - 1);

	logic [7:0] regs_r [0:REG_COUNT-1];
	esp_pkg::esp_state_e state_r;
	logic [7:0] sh_r;
	logic [3:0] cnt_r;
	logic [5:0] ptr_r;
	logic rw_r;
	logic oe_r;
	logic sda_o_r;
	logic wr_en_r;
	logic [5:0] wr_idx_r;
	logic [7:0] wr_dat_r;
	logic scl_s1, scl_s2, scl_d;
	logic sda_s1, sda_s2, sda_d;
	logic asel_s1, asel_s2;
	logic hs_s1, hs_s2;
	logic fld_s1, fld_s2, fld_d;
	logic frame_r;
	esp_pkg::esp_video_ctrl_s ctrl_r;
	logic scl_rise, scl_fall, start_seen, stop_seen;
	logic addr_hit;
	logic [7:0] rd_now;

	// Reset value of a register slot.
	function automatic logic [7:0] reset_val(input logic [5:0] idx);
		case (idx)
			esp_pkg::OFS_MODE_A: reset_val = esp_pkg::RST_MODE_A;
			esp_pkg::OFS_FSC0: reset_val = esp_pkg::RST_FSC[7:0];
			esp_pkg::OFS_FSC1: reset_val = esp_pkg::RST_FSC[15:8];
			esp_pkg::OFS_FSC2: reset_val = esp_pkg::RST_FSC[23:16];
			esp_pkg::OFS_FSC3: reset_val = esp_pkg::RST_FSC[31:24];
			default: reset_val = esp_pkg::RST_OTHER;
		endcase
	endfunction

	// True when a pointer names a decoded register.
	function automatic logic ptr_valid(input logic [5:0] p);
		ptr_valid = (p <= LAST_REG);
	endfunction

	// Register contents for a read, clamped to the top slot.
	function automatic logic [7:0] rd_byte(input logic [5:0] p);
		rd_byte = ptr_valid(p) ? regs_r[p] : regs_r[LAST_REG];
	endfunction

	// Pins come from outside the clock domain, so they pass two flops.
	always_ff @(posedge clk) begin
		scl_s1 <= serial_clock_line;
		scl_s2 <= scl_s1;
		scl_d <= scl_s2;
		sda_s1 <= serial_data_line_i;
		sda_s2 <= sda_s1;
		sda_d <= sda_s2;
		asel_s1 <= addr_select_pin;
		asel_s2 <= asel_s1;
		hs_s1 <= hsync_pin;
		hs_s2 <= hs_s1;
		fld_s1 <= field_pin;
		fld_s2 <= fld_s1;
		fld_d <= fld_s2;
	end

	// Bus events seen on the synchronised lines.
	assign scl_rise = scl_s2 && !scl_d;
	assign scl_fall = !scl_s2 && scl_d;
	assign start_seen = scl_s2 && scl_d && sda_d && !sda_s2;
	assign stop_seen = scl_s2 && scl_d && !sda_d && sda_s2;
	// Address sits in bits 7..1 of the byte; bit 0 is the direction.
	assign addr_hit = (sh_r[7:3] == esp_pkg::DEV_ADDR[6:2]) &&
		(sh_r[2] == asel_s2) && (sh_r[1] == esp_pkg::DEV_ADDR[0]);
	// Byte the pointer names, kept as a net so its top bit can be picked.
	assign rd_now = rd_byte(ptr_r);

	// Protocol engine; data changes only while the clock line is low.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_r <= esp_pkg::ESP_IDLE;
			sh_r <= 8'h00;
			cnt_r <= 4'h0;
			ptr_r <= 6'h00;
			rw_r <= 1'b0;
			oe_r <= 1'b0;
			wr_en_r <= 1'b0;
			wr_idx_r <= 6'h00;
			wr_dat_r <= 8'h00;
		end else begin
			wr_en_r <= 1'b0;
			if (start_seen) begin
				state_r <= esp_pkg::ESP_ADDR;
				cnt_r <= 4'h0;
				oe_r <= 1'b0;
			end else if (stop_seen) begin
				state_r <= esp_pkg::ESP_IDLE;
				oe_r <= 1'b0;
			end else begin
				case (state_r)
					esp_pkg::ESP_ADDR, esp_pkg::ESP_PTR,
					esp_pkg::ESP_WR: begin
						if (scl_rise) begin
							sh_r <= {sh_r[6:0], sda_s2};
							cnt_r <= cnt_r + 4'h1;
						end else if (scl_fall &&
							cnt_r == esp_pkg::BITS_PER_BYTE) begin
							cnt_r <= 4'h0;
							if (state_r == esp_pkg::ESP_ADDR) begin
								if (addr_hit) begin
									oe_r <= 1'b1;
									rw_r <= sh_r[0];
									state_r <= esp_pkg::ESP_ACK_A;
								end else begin
									state_r <= esp_pkg::ESP_IDLE;
								end
							end else if (state_r == esp_pkg::ESP_PTR) begin
								if (ptr_valid(sh_r[5:0])) begin
									ptr_r <= sh_r[5:0];
									oe_r <= 1'b1;
									state_r <= esp_pkg::ESP_ACK_P;
								end else begin
									state_r <= esp_pkg::ESP_IDLE;
								end
							end else if (ptr_valid(ptr_r)) begin
								wr_en_r <= 1'b1;
								wr_idx_r <= ptr_r;
								wr_dat_r <= sh_r;
								ptr_r <= ptr_r + 6'h01;
								oe_r <= 1'b1;
								state_r <= esp_pkg::ESP_ACK_W;
							end else begin
								state_r <= esp_pkg::ESP_IDLE;
							end
						end
					end
					esp_pkg::ESP_ACK_A: begin
						if (scl_fall) begin
							if (rw_r) begin
								sh_r <= rd_now;
								oe_r <= !rd_now[7];
								state_r <= esp_pkg::ESP_RD;
							end else begin
								oe_r <= 1'b0;
								state_r <= esp_pkg::ESP_PTR;
							end
						end
					end
					esp_pkg::ESP_ACK_P, esp_pkg::ESP_ACK_W: begin
						if (scl_fall) begin
							oe_r <= 1'b0;
							state_r <= esp_pkg::ESP_WR;
						end
					end
					esp_pkg::ESP_RD: begin
						if (scl_rise) begin
							cnt_r <= cnt_r + 4'h1;
						end else if (scl_fall) begin
							if (cnt_r == esp_pkg::BITS_PER_BYTE) begin
								oe_r <= 1'b0;
								state_r <= esp_pkg::ESP_RACK;
							end else begin
								oe_r <= !sh_r[6];
								sh_r <= {sh_r[6:0], 1'b0};
							end
						end
					end
					esp_pkg::ESP_RACK: begin
						if (scl_rise) begin
							if (sda_s2) begin
								state_r <= esp_pkg::ESP_IDLE;
							end else begin
								state_r <= esp_pkg::ESP_RLOAD;
								if (ptr_r < LAST_REG) begin
									ptr_r <= ptr_r + 6'h01;
								end
							end
						end
					end
					esp_pkg::ESP_RLOAD: begin
						if (scl_fall) begin
							cnt_r <= 4'h0;
							sh_r <= rd_now;
							oe_r <= !rd_now[7];
							state_r <= esp_pkg::ESP_RD;
						end
					end
					default: begin
						oe_r <= 1'b0;
					end
				endcase
			end
		end
	end

	// Register file; writes land one cycle after the byte is acked.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs_r[i] <= reset_val(6'(i));
			end
		end else if (wr_en_r) begin
			regs_r[wr_idx_r] <= wr_dat_r;
		end
	end

	// Decoded controls, registered so that outputs come from flops.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl_r <= '0;
		end else begin
			ctrl_r.output_standard_sel <=
				regs_r[esp_pkg::OFS_MODE_A][esp_pkg::MA_STD_LO+:2];
			ctrl_r.luma_filter_sel <=
				regs_r[esp_pkg::OFS_MODE_A][esp_pkg::MA_LUMA_LO+:2];
			ctrl_r.pedestal_enable <=
				regs_r[esp_pkg::OFS_MODE_A][esp_pkg::MA_PEDESTAL];
			ctrl_r.colour_bar_enable <=
				regs_r[esp_pkg::OFS_MODE_B][esp_pkg::MB_COLOUR_BAR];
			ctrl_r.master_timing <=
				regs_r[esp_pkg::OFS_TIMING_A][esp_pkg::TA_MASTER] ||
				regs_r[esp_pkg::OFS_MODE_B][esp_pkg::MB_COLOUR_BAR];
			ctrl_r.timing_mode_3 <= (regs_r[esp_pkg::OFS_TIMING_A]
				[esp_pkg::TA_MODE_LO+:2] == esp_pkg::TIMING_MODE_3);
			ctrl_r.pixel_16bit <=
				regs_r[esp_pkg::OFS_TIMING_A][esp_pkg::TA_PIXEL16];
			ctrl_r.auto_blank <=
				!regs_r[esp_pkg::OFS_TIMING_A][esp_pkg::TA_BLANK_EN];
		end
	end

	// Frame start in slave mode 3; in master mode the pins are ours.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			frame_r <= 1'b0;
			field_parity <= 1'b0;
		end else begin
			frame_r <= ctrl_r.timing_mode_3 && !ctrl_r.master_timing &&
				(fld_s2 != fld_d) && hs_s2;
			field_parity <= fld_s2;
		end
	end

	// The data pin is open drain: only the enable ever moves.
	always_ff @(posedge clk) begin
		sda_o_r <= 1'b0;
	end

	assign serial_data_line_o = sda_o_r;
	assign serial_data_line_oe = oe_r;
	assign frame_start = frame_r;
	assign video_ctrl = ctrl_r;

	sequence seq_byte_end;
		scl_fall && !start_seen && !stop_seen &&
			cnt_r == esp_pkg::BITS_PER_BYTE;
	endsequence

	AST_START_GOES_ADDR: assert property (@(posedge clk)
		disable iff (!reset_n) start_seen |=> state_r == esp_pkg::ESP_ADDR)
		else $error("start not taken");
	AST_STOP_GOES_IDLE: assert property (@(posedge clk)
		disable iff (!reset_n) stop_seen && !start_seen |=>
		state_r == esp_pkg::ESP_IDLE && !oe_r)
		else $error("stop did not idle the port");
	AST_ADDR_ACK: assert property (@(posedge clk)
		disable iff (!reset_n) state_r == esp_pkg::ESP_ADDR ##0
		seq_byte_end |=> oe_r == $past(addr_hit))
		else $error("address ack wrong");
	AST_BAD_PTR_NACK: assert property (@(posedge clk)
		disable iff (!reset_n) state_r == esp_pkg::ESP_PTR ##0 seq_byte_end
		##0 !ptr_valid(sh_r[5:0]) |=> state_r == esp_pkg::ESP_IDLE && !oe_r)
		else $error("invalid pointer was acked");
	AST_WR_OVERRUN: assert property (@(posedge clk)
		disable iff (!reset_n) state_r == esp_pkg::ESP_WR ##0 seq_byte_end
		##0 !ptr_valid(ptr_r) |=> !wr_en_r && !oe_r &&
		state_r == esp_pkg::ESP_IDLE)
		else $error("overrun write not discarded");
	AST_WR_ADVANCE: assert property (@(posedge clk)
		disable iff (!reset_n) state_r == esp_pkg::ESP_WR ##0 seq_byte_end
		##0 ptr_valid(ptr_r) |=> wr_en_r && ptr_r == $past(ptr_r) + 6'h01
		##1 regs_r[$past(wr_idx_r)] == $past(wr_dat_r))
		else $error("write byte not stored");
	AST_RD_SATURATE: assert property (@(posedge clk)
		disable iff (!reset_n) ptr_r == LAST_REG &&
		state_r == esp_pkg::ESP_RACK |=> ptr_r == LAST_REG)
		else $error("read pointer left the top register");
	AST_RESET_DEFAULTS: assert property (@(posedge clk)
		!reset_n |=> regs_r[esp_pkg::OFS_MODE_A] == esp_pkg::RST_MODE_A &&
		regs_r[esp_pkg::OFS_FSC3] == esp_pkg::RST_FSC[31:24] &&
		regs_r[esp_pkg::OFS_MODE_B] == esp_pkg::RST_OTHER)
		else $error("reset defaults wrong");
	AST_COLOUR_MASTER: assert property (@(posedge clk)
		disable iff (!reset_n) regs_r[esp_pkg::OFS_MODE_B]
		[esp_pkg::MB_COLOUR_BAR] |=> ctrl_r.master_timing)
		else $error("colour bars did not force master");
	AST_FRAME_EDGE: assert property (@(posedge clk)
		disable iff (!reset_n) ctrl_r.timing_mode_3 && !ctrl_r.master_timing
		&& $changed(fld_s2) && hs_s2 |=> frame_r ##1 !frame_r || $changed(fld_s2))
		else $error("mode 3 frame start missed");
	AST_AUTO_BLANK: assert property (@(posedge clk)
		disable iff (!reset_n) !regs_r[esp_pkg::OFS_TIMING_A]
		[esp_pkg::TA_BLANK_EN] [*2] |-> ctrl_r.auto_blank)
		else $error("auto blanking not enabled");
endmodule // esp_serial_port

// ---- design/esp_pkg.sv ----
// Shared constants and types of the encoder serial register port.
package esp_pkg;
	localparam int REG_COUNT_CP = 36;
	localparam int REG_COUNT_PLAIN = 31;
	localparam logic [5:0] OFS_MODE_A = 6'h00;
	localparam logic [5:0] OFS_MODE_B = 6'h01;
	localparam logic [5:0] OFS_FSC0 = 6'h02;
	localparam logic [5:0] OFS_FSC1 = 6'h03;
	localparam logic [5:0] OFS_FSC2 = 6'h04;
	localparam logic [5:0] OFS_FSC3 = 6'h05;
	localparam logic [5:0] OFS_TIMING_A = 6'h07;
	localparam logic [7:0] RST_MODE_A = 8'h04;
	localparam logic [31:0] RST_FSC = 32'h21f07c16;
	localparam logic [7:0] RST_OTHER = 8'h00;
	// Field positions in mode_control_a.
	localparam int MA_STD_LO = 0;
	localparam int MA_PEDESTAL = 2;
	localparam int MA_LUMA_LO = 3;
	// Field positions in mode_control_b and timing_config_a.
	localparam int MB_COLOUR_BAR = 7;
	localparam int TA_MASTER = 0;
	localparam int TA_MODE_LO = 1;
	localparam int TA_BLANK_EN = 3;
	localparam int TA_PIXEL16 = 6;
	localparam logic [1:0] TIMING_MODE_3 = 2'h3;
	// Serial address; the value is arbitrary, bit one comes from a pin.
	localparam logic [6:0] DEV_ADDR = 7'h2a;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum {
		ESP_IDLE, ESP_ADDR, ESP_ACK_A, ESP_PTR, ESP_ACK_P,
		ESP_WR, ESP_ACK_W, ESP_RD, ESP_RACK, ESP_RLOAD
	} esp_state_e;

	typedef struct packed {
		logic [1:0] output_standard_sel;
		logic [1:0] luma_filter_sel;
		logic pedestal_enable;
		logic colour_bar_enable;
		logic master_timing;
		logic timing_mode_3;
		logic pixel_16bit;
		logic auto_blank;
	} esp_video_ctrl_s;
endpackage

// ---- test/esp_host_model.sv ----
// Two-wire bus host model driving the clock and the open-drain data line.
module esp_host_model (
	input wire logic clk, // Bench clock that paces the bus.
	input wire logic sda, // Resolved data line level.
	output logic scl, // Bus clock, idle high between frames.
	output logic sda_oe // High while pulling data low.
);
	timeunit 1ns;
	timeprecision 1ns;
	// The line has a pull-up, so a released line reads high.
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	// A quarter of the 400 ns bus period is two bench clocks.
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Data moves only with the clock low; it is sampled late in the high
	// phase because the device answers a few clocks after the falling edge.
	task automatic bit_io(input logic b, output logic r);
		wt(2);
		sda_oe <= !b;
		wt(2);
		scl <= 1'b1;
		wt(3);
		@(negedge clk) r = sda;
		wt(1);
		scl <= 1'b0;
	endtask
	// One start per high phase; it also serves as a repeated start.
	task automatic start();
		wt(2);
		sda_oe <= 1'b0;
		wt(2);
		scl <= 1'b1;
		wt(2);
		sda_oe <= 1'b1;
		wt(2);
		scl <= 1'b0;
	endtask
	// One stop per high phase, after which the clock stands still high.
	task automatic stop();
		wt(2);
		sda_oe <= 1'b1;
		wt(2);
		scl <= 1'b1;
		wt(2);
		sda_oe <= 1'b0;
		wt(4);
	endtask
	// Eight bits most significant first, then the ninth acknowledge bit.
	task automatic xfer(input logic [7:0] d, input logic n9,
		output logic [7:0] r, output logic r9);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(n9, r9);
	endtask
endmodule // esp_host_model

// ---- test/esp_serial_port_test.sv ----
// Self-checking bench of the serial register port.
module esp_serial_port_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic addr_sel = 1'b0;
	logic hsync = 1'b0;
	logic field = 1'b0;
	logic scl, host_oe, sda_oe, sda_o, fs, fpar;
	esp_pkg::esp_video_ctrl_s vc;
	logic [7:0] mem [36];
	int num_errors = 0;
	int compares = 0;
	int pulses = 0;
	// Wired-AND data line with a pull-up.
	wire logic sda = !(host_oe | sda_oe);

	always #25 clk = ~clk;
	// Frame pulses are counted so a double pulse shows up too.
	always @(posedge clk)
		if (fs === 1'b1)
			pulses <= pulses + 1;

	esp_serial_port #(.COPY_PROTECT(1'b1)) uut (
		.clk(clk), .reset_n(reset_n), .serial_clock_line(scl),
		.serial_data_line_i(sda), .serial_data_line_o(sda_o),
		.serial_data_line_oe(sda_oe), .addr_select_pin(addr_sel),
		.hsync_pin(hsync), .field_pin(field), .frame_start(fs),
		.field_parity(fpar), .video_ctrl(vc));
	esp_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(host_oe));

	task automatic check(input string nm, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Address byte follows the select pin in bit two, which is address bit one.
	function automatic logic [7:0] dev(input logic rw);
		return {esp_pkg::DEV_ADDR[6:2], addr_sel, esp_pkg::DEV_ADDR[0], rw};
	endfunction
	// Decode expected from the register image.
	function automatic esp_pkg::esp_video_ctrl_s vexp();
		return {mem[0][1:0], mem[0][4:3], mem[0][2], mem[1][7],
			mem[7][0] | mem[1][7], mem[7][2:1] == 2'h3, mem[7][6],
			!mem[7][3]};
	endfunction
	// Start, address for write and pointer; acks come back active low.
	task automatic head(input int p, output logic [1:0] a);
		logic [7:0] d;
		host.start();
		host.xfer(dev(1'b0), 1'b1, d, a[1]);
		host.xfer(p[7:0], 1'b1, d, a[0]);
	endtask
	// Writes n bytes of the register image starting at p.
	task automatic wr(input int p, input int n);
		logic [1:0] a;
		logic [7:0] d;
		logic q;
		head(p, a);
		check("head ack", a, 2'b00);
		for (int i = 0; i < n; i++) begin
			host.xfer(mem[p + i], 1'b1, d, q);
			check("data ack", q, 1'b0);
		end
		host.stop();
	endtask
	// Reads n bytes from p; past the last register it must repeat.
	task automatic rd(input int p, input int n);
		logic [1:0] a;
		logic [7:0] d;
		logic q;
		head(p, a);
		host.start();
		host.xfer(dev(1'b1), 1'b1, d, q);
		check("read ack", {a, q}, 3'b000);
		for (int i = 0; i < n; i++) begin
			host.xfer(8'hff, i == n - 1, d, q);
			check("read data", d, mem[(p + i > 35) ? 35 : p + i]);
		end
		host.stop();
	endtask

	initial begin
		logic [1:0] a;
		logic [7:0] d;
		logic q;
		int p0;
		void'($urandom(32'h4a8ea93e));
		foreach (mem[i])
			mem[i] = esp_pkg::RST_OTHER;
		mem[0] = esp_pkg::RST_MODE_A;
		{mem[5], mem[4], mem[3], mem[2]} = esp_pkg::RST_FSC;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		check("ctrl reset", vc, vexp());
		rd(0, 38);
		$display("test reset defaults done");
		// Subcarrier bytes go in one run from the lowest of them.
		for (int i = 2; i < 6; i++)
			mem[i] = 8'($urandom);
		wr(2, 4);
		for (int t = 0; t < 8; t++) begin
			addr_sel <= 1'($urandom);
			p0 = $urandom_range(33, 8);
			for (int i = 0; i < 3; i++)
				mem[p0 + i] = 8'($urandom);
			wr(p0, 3);
			mem[0] = 8'($urandom);
			mem[1] = 8'($urandom);
			mem[7] = 8'($urandom);
			wr(0, 2);
			wr(7, 1);
			check("ctrl decode", vc, vexp());
		end
		rd(0, 36);
		$display("test random writes done");
		// A foreign address must not be acknowledged.
		host.start();
		host.xfer(dev(1'b0) ^ 8'h04, 1'b1, d, q);
		check("foreign ack", q, 1'b1);
		host.stop();
		head(36, a);
		check("bad pointer", a, 2'b01);
		host.stop();
		// Last register takes one byte, the next one is refused.
		head(35, a);
		mem[35] = 8'($urandom);
		host.xfer(mem[35], 1'b1, d, q);
		check("last reg ack", q, 1'b0);
		host.xfer(~mem[35], 1'b1, d, q);
		check("past end ack", q, 1'b1);
		host.stop();
		rd(35, 1);
		// A stop in mid-byte must abandon the write.
		head(0, a);
		for (int i = 0; i < 3; i++)
			host.bit_io(1'b0, q);
		host.stop();
		rd(0, 1);
		$display("test refusals done");
		mem[1] = 8'h00;
		wr(1, 1);
		mem[7] = 8'h06;
		wr(7, 1);
		// Field change counts only with line sync high and slave timing.
		for (int t = 0; t < 4; t++) begin
			if (t == 3) begin
				mem[1] = 8'h80;
				wr(1, 1);
			end
			hsync <= (t != 2);
			repeat (10) @(posedge clk);
			p0 = pulses;
			field <= !field;
			repeat (10) @(posedge clk);
			check("frame pulses", pulses - p0, t < 2);
			check("field level", fpar, field);
		end
		$display("test frame start done");
		end_sim();
	end
	// Watchdog well beyond the expected run length.
	initial begin
		#4000000;
		num_errors++;
		end_sim();
	end
endmodule // esp_serial_port_test
